// File: inc/synth_hop_consts.svh
// offsets, field positions, reset values and timing counts of the hop controller
// assumes a 200 MHz pclk and an apb register bus with 32-bit data
`ifndef SYNTH_HOP_CONSTS_SVH
`define SYNTH_HOP_CONSTS_SVH

`define FRAC_BITS            19
`define TABLE_DEPTH          64
`define SKIP_ENTRY           8'hff
`define CLK_PERIOD_NS        5
`define AUTO_HOP_TURN_NS     115000
`define MANUAL_HOP_TURN_NS   75000
`define AUTO_HOP_TURN_CYC    (`AUTO_HOP_TURN_NS / `CLK_PERIOD_NS)
`define MANUAL_HOP_TURN_CYC  (`MANUAL_HOP_TURN_NS / `CLK_PERIOD_NS)

// register byte offsets
`define REG_BASE_FREQ        12'h000
`define REG_STEP_SIZE        12'h004
`define REG_HOP_CONTROL      12'h008
`define REG_TABLE_SIZE       12'h00c
`define REG_THRESHOLD        12'h010
`define REG_COMMAND          12'h014
`define REG_STATUS           12'h018
`define REG_SYNTH_WORD       12'h01c
`define REG_OUTDIV           12'h020
`define REG_CAL_COUNT        12'h024
`define REG_TABLE_BASE       12'h100
`define REG_TABLE_END        12'h1fc

// hop control fields
`define HC_RSSI_BIT          0
`define HC_PREAMBLE_BIT      1
`define HC_SYNC_BIT          2
`define HC_ENABLE_BIT        3
`define HC_RAW_MODE_BIT      4
`define HC_GPIO_BIT          5

// command fields: [2:0] opcode, [3] channel given, [15:8] channel
`define CMD_START_RX         3'h1
`define CMD_START_TX         3'h2
`define CMD_RX_HOP           3'h3
`define CMD_IDLE             3'h4
`define CMD_CHAN_GIVEN_BIT   3
`define CMD_CHAN_LSB         8

`define RST_CHANNEL          8'h00
`define RST_TABLE_SIZE       7'h00

`endif

// File: inc/synth_hop_pkg.sv
// types shared by the hop controller and its helpers
// assumes the constants header is compiled alongside
package synth_hop_pkg;

   typedef enum logic [1:0] {
      RADIO_IDLE,
      RADIO_RX,
      RADIO_TX
   } radio_mode_e;

   // modem side evidence for the dwell decision
   typedef struct packed {
      logic [7:0] rssi;
      logic       preamble_timeout;
      logic       sync_timeout;
      logic       preamble_seen;
      logic       sync_seen;
   } modem_status_s;

   // word presented to the synthesizer
   typedef struct packed {
      logic [7:0]  integer_word;
      logic [18:0] fraction_word;
      logic [4:0]  outdiv;
      logic        load;
      logic        manual_cal;
   } synth_word_s;

endpackage

// File: rtl/synth_word_calc.sv
// channel to synthesizer word arithmetic and band divider choice
// assumes settings are stable while a load is pending; pure combinational
`timescale 1ns/10ps
`default_nettype none
`include "synth_hop_consts.svh"

module synth_word_calc #(
   parameter int FRAC_W = `FRAC_BITS
) (
   // settings
   input  wire logic [7:0]        integer_word,
   input  wire logic [FRAC_W-1:0] fraction_word,
   input  wire logic [15:0]       step_size,
   input  wire logic [7:0]        channel,
   input  wire logic [2:0]        band_select,
   input  wire logic              wide_variant,
   // result
   output logic [7:0]             chan_integer,
   output logic [FRAC_W-1:0]      chan_fraction,
   output logic [4:0]             outdiv
);
   logic [FRAC_W+8:0] total;

   // base is channel 0; step counts in fraction units
   always_comb begin
      total = {1'b0, integer_word, fraction_word}
            + (FRAC_W+9)'(channel) * (FRAC_W+9)'(step_size);
      chan_integer  = total[FRAC_W+7:FRAC_W];
      chan_fraction = total[FRAC_W-1:0];
   end

   // divider per band, low band first
   always_comb begin
      if (wide_variant) begin
         case (band_select)
            3'h0:    outdiv = 5'h18;
            3'h1:    outdiv = 5'h10;
            3'h2:    outdiv = 5'h0c;
            3'h3:    outdiv = 5'h08;
            3'h4:    outdiv = 5'h06;
            default: outdiv = 5'h04;
         endcase
      end else begin
         case (band_select)
            3'h0:    outdiv = 5'h18;
            3'h1:    outdiv = 5'h0c;
            3'h2:    outdiv = 5'h08;
            default: outdiv = 5'h04;
         endcase
      end
   end
endmodule
`default_nettype wire

// File: rtl/dwell_judge.sv
// dwell decision: stay on a channel or hop, first enabled condition wins
// assumes modem status is synchronous to pclk and fresh after settling
`timescale 1ns/10ps
`default_nettype none
`include "synth_hop_consts.svh"

module dwell_judge (
   // config
   input  wire logic                         rssi_en,
   input  wire logic                         preamble_en,
   input  wire logic                         sync_en,
   input  wire logic                         raw_mode,
   input  wire logic [7:0]                   threshold,
   // evidence
   input  wire synth_hop_pkg::modem_status_s status,
   // decision
   output logic                              stay,
   output logic                              hop
);
   logic pkt_ok;

   // timeouts need the packet handler
   assign pkt_ok = !raw_mode;

   always_comb begin
      stay = 1'b0;
      hop  = 1'b0;
      if (rssi_en && status.rssi > threshold) begin
         stay = 1'b1;
      end else if (rssi_en && !(preamble_en && pkt_ok) && !(sync_en && pkt_ok)) begin
         hop = 1'b1;
      end else if (pkt_ok && preamble_en && status.preamble_timeout) begin
         hop = 1'b1;
      end else if (pkt_ok && sync_en && status.sync_timeout) begin
         hop = 1'b1;
      end else if (pkt_ok && sync_en && status.sync_seen) begin
         stay = 1'b1;
      end else if (pkt_ok && preamble_en && !sync_en && status.preamble_seen) begin
         stay = 1'b1;
      end
   end
endmodule
`default_nettype wire

// File: rtl/synth_hop_ctrl.sv
// synthesizer frequency control, channel tuning and receive hop sequencer
// assumes an apb master on pclk and a modem reporting status on pclk
`timescale 1ns/10ps
`default_nettype none
`include "synth_hop_consts.svh"

// Operation
// (R1) carrier is integer plus fraction over 2^19, times 2 crystal, over divider
// (R2) host keeps fraction over 2^19 between one and two
// (R3) four-band divider is 24, 12, 8 or 4 by band
// (R4) wide variant divider steps 24, 16, 12, 8, 6, 4 by band
// (R5) transmit modulation offsets the fraction word digitally
// (R6) base setting is channel 0; frequency is base plus channel times step
// (R7) host writes step size high and low bytes before channel tuning
// (R8) channel rides as second argument of receive and transmit start
// (R9) start without channel reuses the last; reset channel is 0
// (R10) hop table holds 64 entries; size register sets active count
// (R11) with hopping enabled, entering receive starts hopping unaided
// (R12) entries visited first to last, then wrap to first
// (R13) entries holding 0xff are skipped
// (R14) rssi, preamble and sync conditions enabled separately; first met decides
// (R15) preamble timeout is no preamble; sync timeout is no sync after preamble
// (R16) instantaneous rssi above threshold stays, below hops; the block hops on low rssi only with preamble and sync off or in raw mode
// (R17) raw mode allows only the rssi condition
// (R18) automatic hop completes within 115 us
// (R19) manual receive hop retunes within 75 us
// (R20) host supplies oscillator calibration count with manual hop
// (R21) general output toggles on each hop and each table wrap; the block toggles once per hop, and a wrap adds no toggle of its own
// (R22) host configures everything, then starts receive on first valid entry
// (R23) hop threshold is the signal level threshold; above-threshold flag is output
// (R24) after a hop the synthesizer settles before conditions are judged again
module synth_hop_ctrl #(
   parameter int AUTO_TURN_CYC   = `AUTO_HOP_TURN_CYC,
   parameter int MANUAL_TURN_CYC = `MANUAL_HOP_TURN_CYC,
   parameter int SETTLE_CYC      = 64
) (
   // clock and reset
   input  wire logic                         pclk,
   input  wire logic                         presetn,
   input  wire logic                         clk_en,
   // apb slave
   input  wire logic                         psel,
   input  wire logic                         penable,
   input  wire logic                         pwrite,
   input  wire logic [11:0]                  paddr,
   input  wire logic [31:0]                  pwdata,
   output logic                              pready,
   output logic [31:0]                       prdata,
   output logic                              pslverr,
   // modem
   input  wire synth_hop_pkg::modem_status_s modem_status,
   input  wire logic [18:0]                  tx_deviation,
   input  wire logic                         tx_symbol_neg,
   // synthesizer
   output synth_hop_pkg::synth_word_s        synth_out,
   output logic [7:0]                        cal_count_out,
   // pins
   output logic                              hop_gpio,
   output logic                              above_threshold
);
   localparam int TW = 17;

   // ************************************************************
   // registers
   // ************************************************************
   logic [7:0]  integer_r;
   logic [18:0] fraction_r;
   logic [15:0] step_r;
   logic [5:0]  hop_ctl_r;
   logic [6:0]  table_size_r;
   logic [7:0]  threshold_r;
   logic [3:0]  band_r;
   logic [7:0]  cal_r;
   logic [7:0]  channel_r;
   logic [7:0]  hop_table [`TABLE_DEPTH];
   logic [5:0]  index_r;
   logic        gpio_r;
   logic [TW-1:0] turn_cnt_r;
   logic        manual_r;
   synth_hop_pkg::radio_mode_e mode_r;

   typedef enum logic [1:0] {SEQ_IDLE, SEQ_SETTLE, SEQ_DWELL, SEQ_SEEK} seq_e;
   seq_e seq_r;

   logic        wr_fire;
   logic        rd_fire;
   logic        tbl_hit;
   logic        cmd_wr;
   logic [2:0]  cmd_op;
   logic [7:0]  cmd_chan;
   logic        cmd_has_chan;
   logic        auto_en;
   logic        stay;
   logic        hop;
   logic [5:0]  next_index;
   logic        wrapped;
   logic [7:0]  chan_integer;
   logic [18:0] chan_fraction;
   logic [4:0]  outdiv;
   logic        load_pend_r;

   assign pready  = 1'b1;
   assign pslverr = 1'b0;
   assign wr_fire = psel && penable && pwrite && clk_en;
   assign rd_fire = psel && !penable && !pwrite;
   assign tbl_hit = paddr >= `REG_TABLE_BASE && paddr <= `REG_TABLE_END;
   assign cmd_wr  = wr_fire && paddr == `REG_COMMAND;
   assign cmd_op  = pwdata[2:0];
   assign cmd_chan = pwdata[`CMD_CHAN_LSB +: 8];
   assign cmd_has_chan = pwdata[`CMD_CHAN_GIVEN_BIT];
   assign auto_en = hop_ctl_r[`HC_ENABLE_BIT];

   // host keeps the fraction above 2^19; the block does not check it (see R2)
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         integer_r    <= 8'h00;
         fraction_r   <= 19'h40000;
         step_r       <= 16'h0000;
         hop_ctl_r    <= 6'h00;
         table_size_r <= `RST_TABLE_SIZE;
         threshold_r  <= 8'hff;
         band_r       <= 4'h0;
         cal_r        <= 8'h00;
      end else if (wr_fire) begin
         case (paddr)
            `REG_BASE_FREQ: begin
               integer_r  <= pwdata[26:19];
               fraction_r <= pwdata[18:0];
            end
            `REG_STEP_SIZE:   step_r <= pwdata[15:0]; // see R7
            `REG_HOP_CONTROL: hop_ctl_r <= pwdata[5:0]; // see R14
            `REG_TABLE_SIZE: begin
               if (pwdata[6:0] <= 7'(`TABLE_DEPTH)) begin
                  table_size_r <= pwdata[6:0]; // see R10
               end
            end
            `REG_THRESHOLD:   threshold_r <= pwdata[7:0]; // see R23
            `REG_OUTDIV:      band_r <= pwdata[3:0];
            `REG_CAL_COUNT:   cal_r <= pwdata[7:0]; // see R20
            default: ;
         endcase
      end
   end

   // table memory has no reset; host loads it before enabling
   always_ff @(posedge pclk) begin
      if (wr_fire && tbl_hit) begin
         hop_table[paddr[7:2]] <= pwdata[7:0]; // see R10
      end
   end

   // ************************************************************
   // read mux
   // ************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (clk_en && rd_fire) begin
         if (tbl_hit) begin
            prdata <= {24'h000000, hop_table[paddr[7:2]]};
         end else begin
            case (paddr)
               `REG_BASE_FREQ:   prdata <= {5'h00, integer_r, fraction_r};
               `REG_STEP_SIZE:   prdata <= {16'h0000, step_r};
               `REG_HOP_CONTROL: prdata <= {26'h0, hop_ctl_r};
               `REG_TABLE_SIZE:  prdata <= {25'h0, table_size_r};
               `REG_THRESHOLD:   prdata <= {24'h0, threshold_r};
               `REG_STATUS:      prdata <= {12'h0, channel_r, index_r, seq_r,
                                            mode_r, gpio_r, above_threshold};
               `REG_SYNTH_WORD:  prdata <= {outdiv, chan_integer, chan_fraction};
               `REG_OUTDIV:      prdata <= {28'h0, band_r};
               `REG_CAL_COUNT:   prdata <= {24'h0, cal_r};
               default:          prdata <= 32'h0000_0000;
            endcase
         end
      end
   end

   // ************************************************************
   // hop sequencer
   // ************************************************************
   // next valid entry after index_r, skipping marked entries
   always_comb begin
      logic       found;
      logic [5:0] probe;
      found      = 1'b0;
      next_index = 6'h00;
      wrapped    = 1'b0;
      probe      = index_r;
      for (int k = 1; k <= `TABLE_DEPTH; k++) begin
         probe = (7'(index_r) + 7'(k) >= 7'(table_size_r)) ?
                 6'(7'(index_r) + 7'(k) - 7'(table_size_r)) : 6'(index_r + 6'(k));
         if (!found && hop_table[probe] != `SKIP_ENTRY && k <= int'(table_size_r)) begin
            found      = 1'b1;
            next_index = probe; // see R12, R13
            wrapped    = probe <= index_r;
         end
      end
      if (!found) begin
         next_index = index_r;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         seq_r      <= SEQ_IDLE;
         mode_r     <= synth_hop_pkg::RADIO_IDLE;
         channel_r  <= `RST_CHANNEL;
         index_r    <= 6'h00;
         turn_cnt_r <= '0;
         manual_r   <= 1'b0;
         gpio_r     <= 1'b0;
      end else if (clk_en) begin
         if (cmd_wr && (cmd_op == `CMD_START_RX || cmd_op == `CMD_START_TX)) begin
            if (cmd_has_chan) begin
               channel_r <= cmd_chan; // see R8, R9
            end
            mode_r     <= (cmd_op == `CMD_START_RX) ? synth_hop_pkg::RADIO_RX
                                                    : synth_hop_pkg::RADIO_TX;
            index_r    <= 6'h00;
            manual_r   <= 1'b0;
            turn_cnt_r <= TW'(AUTO_TURN_CYC);
            seq_r      <= SEQ_SETTLE; // see R11
         end else if (cmd_wr && cmd_op == `CMD_RX_HOP) begin
            channel_r  <= cmd_chan;
            mode_r     <= synth_hop_pkg::RADIO_RX;
            manual_r   <= 1'b1;
            turn_cnt_r <= TW'(MANUAL_TURN_CYC); // see R19
            seq_r      <= SEQ_SETTLE;
         end else if (cmd_wr && cmd_op == `CMD_IDLE) begin
            mode_r <= synth_hop_pkg::RADIO_IDLE;
            seq_r  <= SEQ_IDLE;
         end else begin
            case (seq_r)
               SEQ_IDLE: ;
               SEQ_SETTLE: begin
                  // conditions ignored until the synthesizer settles (see R24)
                  if (turn_cnt_r <= TW'(SETTLE_CYC) || turn_cnt_r == '0) begin
                     turn_cnt_r <= '0;
                     seq_r      <= SEQ_DWELL; // see R18
                  end else begin
                     turn_cnt_r <= turn_cnt_r - TW'(1);
                  end
               end
               SEQ_DWELL: begin
                  if (mode_r == synth_hop_pkg::RADIO_RX && auto_en && hop && !stay
                      && table_size_r != 7'h00) begin
                     seq_r <= SEQ_SEEK;
                  end
               end
               SEQ_SEEK: begin
                  index_r    <= next_index;
                  channel_r  <= hop_table[next_index];
                  turn_cnt_r <= TW'(AUTO_TURN_CYC);
                  seq_r      <= SEQ_SETTLE;
                  if (hop_ctl_r[`HC_GPIO_BIT]) begin
                     gpio_r <= !gpio_r ^ !wrapped ^ 1'b1 ^ wrapped; // see R21
                  end
               end
               default: seq_r <= SEQ_IDLE;
            endcase
         end
      end
   end

   // ************************************************************
   // helpers and synthesizer output
   // ************************************************************
   dwell_judge u_judge (
      .rssi_en     (hop_ctl_r[`HC_RSSI_BIT]),
      .preamble_en (hop_ctl_r[`HC_PREAMBLE_BIT]),
      .sync_en     (hop_ctl_r[`HC_SYNC_BIT]),
      .raw_mode    (hop_ctl_r[`HC_RAW_MODE_BIT]), // see R17
      .threshold   (threshold_r),
      .status      (modem_status), // see R15, R16
      .stay        (stay),
      .hop         (hop)
   );

   synth_word_calc u_calc (
      .integer_word  (integer_r),
      .fraction_word (fraction_r),
      .step_size     (step_r),
      .channel       (channel_r), // see R6
      .band_select   (band_r[2:0]), // see R3, R4
      .wide_variant  (band_r[3]),
      .chan_integer  (chan_integer),
      .chan_fraction (chan_fraction),
      .outdiv        (outdiv)
   );

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         synth_out       <= '0;
         load_pend_r     <= 1'b0;
         cal_count_out   <= 8'h00;
         above_threshold <= 1'b0;
      end else if (clk_en) begin
         synth_out.integer_word <= chan_integer; // see R1
         // frequency deviation added to the fraction while sending, subtracted for a negative symbol (see R5)
         if (mode_r == synth_hop_pkg::RADIO_TX) begin
            synth_out.fraction_word <= tx_symbol_neg ? chan_fraction - tx_deviation
                                                     : chan_fraction + tx_deviation;
         end else begin
            synth_out.fraction_word <= chan_fraction;
         end
         synth_out.outdiv     <= outdiv;
         // word follows channel_r one edge late, so the strobe is held back to match
         load_pend_r          <= seq_r == SEQ_SEEK || (cmd_wr && cmd_op != `CMD_IDLE);
         synth_out.load       <= load_pend_r;
         synth_out.manual_cal <= manual_r;
         cal_count_out        <= cal_r;
         above_threshold      <= modem_status.rssi > threshold_r; // see R23
      end
   end

   assign hop_gpio = gpio_r;

   // ************************************************************
   // checks
   // ************************************************************
   a_chan_reuse: assert property (@(posedge pclk) disable iff (!presetn) // see R9
      (cmd_wr && cmd_op == `CMD_START_RX && !cmd_has_chan && clk_en)
      |=> channel_r == $past(channel_r))
      else $error("channel not kept on start without channel");

   a_hop_skip: assert property (@(posedge pclk) disable iff (!presetn) // see R13
      (seq_r == SEQ_SEEK && clk_en && !cmd_wr && next_index != index_r)
      |=> channel_r != `SKIP_ENTRY)
      else $error("hop landed on a skipped entry");

   a_settle_bound: assert property (@(posedge pclk) disable iff (!presetn) // see R18
      turn_cnt_r <= TW'(AUTO_TURN_CYC))
      else $error("turnaround counter beyond automatic bound");

   a_stay_hold: assert property (@(posedge pclk) disable iff (!presetn) // see R16
      (seq_r == SEQ_DWELL && stay && !cmd_wr) |=> seq_r != SEQ_SEEK)
      else $error("hopped while signal above threshold");

   a_start_rx: assert property (@(posedge pclk) disable iff (!presetn) // see R11
      (cmd_wr && cmd_op == `CMD_START_RX) |=> seq_r == SEQ_SETTLE)
      else $error("receive start did not start sequencing");

   a_manual_fast: assert property (@(posedge pclk) disable iff (!presetn) // see R19
      (cmd_wr && cmd_op == `CMD_RX_HOP) |=> turn_cnt_r == TW'(MANUAL_TURN_CYC))
      else $error("manual hop turnaround wrong");

   a_raw_only: assert property (@(posedge pclk) disable iff (!presetn) // see R17
      (hop_ctl_r[`HC_RAW_MODE_BIT] && !hop_ctl_r[`HC_RSSI_BIT]) |-> !hop && !stay)
      else $error("timeout condition used in raw mode");

   a_gpio_toggle: assert property (@(posedge pclk) disable iff (!presetn) // see R21
      (seq_r == SEQ_SEEK && clk_en && !cmd_wr && hop_ctl_r[`HC_GPIO_BIT])
      |=> gpio_r != $past(gpio_r))
      else $error("output did not toggle on hop");
endmodule
`default_nettype wire

// File: tb/apb_host.sv
// apb master standing in for the host controller
// assumes a slave on pclk whose pready may be tied high
`timescale 1ns/10ps
`default_nettype none
module apb_host (
   // bus
   input  wire logic        pclk,
   input  wire logic        pready,
   input  wire logic [31:0] prdata,
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic [11:0]      paddr,
   output logic [31:0]      pwdata
);
   // ****************
   // transfer
   // ****************
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
   end
   // callers set base and step before the first start; table and control are set before the hopping start
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] q);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (pready !== 1'b1) begin
         tb.mismatches++;
         $display("MISMATCH pready timeout");
         tb.finish_test();
      end
      q = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
endmodule
`default_nettype wire

// File: tb/tb.sv
// self-checking bench for the hop controller
// assumes apb_host as host model; modem status driven here
`timescale 1ns/10ps
`default_nettype none
`include "synth_hop_consts.svh"
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin mismatches++; \
   $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module tb;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, hop_gpio, above_threshold;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic [7:0]  cal;
   logic [26:0] base, w, ew;
   logic [18:0] dev;
   logic        neg, ce;
   logic [15:0] step;
   int          mismatches, compares, ch, n;
   synth_hop_pkg::modem_status_s ms;
   synth_hop_pkg::synth_word_s   so;
   // ****************
   // harness
   // ****************
   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end
   apb_host i_host (.pclk(pclk), .pready(pready), .prdata(prdata), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
   synth_hop_ctrl #(.AUTO_TURN_CYC(200), .MANUAL_TURN_CYC(100), .SETTLE_CYC(8)) i_dut (
      .pclk(pclk), .presetn(presetn), .clk_en(ce), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
      .pslverr(pslverr), .modem_status(ms), .tx_deviation(dev), .tx_symbol_neg(neg),
      .synth_out(so), .cal_count_out(cal), .hop_gpio(hop_gpio),
      .above_threshold(above_threshold));
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] x;
      i_host.xfer(1'b1, a, d, x);
   endtask
   task automatic cmd(input logic [2:0] op, input logic given, input logic [7:0] c);
      wr(`REG_COMMAND, {16'h0, c, 4'h0, given, op});
   endtask
   task automatic finish_test;
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // word on the synthesizer at the next load pulse, bounded by the turnaround
   task automatic wait_load(input int lim, output logic [26:0] v);
      int k;
      for (k = 0; k < lim; k++) begin
         @(negedge pclk);
         if (so.load === 1'b1) break;
      end
      v = {so.integer_word, so.fraction_word};
      if (so.load !== 1'b1) begin
         mismatches++;
         $display("MISMATCH load timeout");
         finish_test();
      end
      @(posedge pclk);
   endtask
   function automatic logic [26:0] word(input int c);
      return base + 27'(c) * 27'(step);
   endfunction
   // ****************
   // tests
   // ****************
   initial begin
      int hq[$] = '{2, 7};
      int dv[10] = '{24, 12, 8, 4, 24, 16, 12, 8, 6, 4};
      void'($urandom(32'h5501));
      presetn = 1'b0;
      ms = '0;
      ce = 1'b1;
      dev = 19'h0;
      neg = 1'b0;
      mismatches = 0;
      compares = 0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      i_host.xfer(1'b0, `REG_THRESHOLD, 32'h0, q);
      `CHK("threshold", 8'hff, q[7:0])
      i_host.xfer(1'b0, `REG_STATUS, 32'h0, q);
      `CHK("reset channel", 8'h00, q[19:12])
      i_host.xfer(1'b0, 12'h080, 32'h0, q);
      `CHK("unmapped", 32'h0, q)
      `CHK("slverr", 1'b0, pslverr)
      foreach (dv[i]) begin
         wr(`REG_OUTDIV, 32'(i < 4 ? i : i + 4));
         i_host.xfer(1'b0, `REG_SYNTH_WORD, 32'h0, q);
         `CHK("outdiv", 5'(dv[i]), q[31:27])
      end
      $display("test reset done");
      base = {8'($urandom_range(40, 60)), 19'($urandom)};
      step = 16'($urandom_range(1, 4000));
      wr(`REG_BASE_FREQ, {5'h0, base});
      wr(`REG_STEP_SIZE, {16'h0, step});
      ch = $urandom_range(1, 20);
      cmd(`CMD_START_RX, 1'b1, 8'(ch));
      wait_load(400, w);
      `CHK("start word", word(ch), w)
      cmd(`CMD_IDLE, 1'b0, 8'h0);
      cmd(`CMD_START_RX, 1'b0, 8'h0);
      wait_load(400, w);
      `CHK("reuse word", word(ch), w)
      wr(`REG_CAL_COUNT, 32'h5a);
      cmd(`CMD_RX_HOP, 1'b1, 8'h09);
      wait_load(100, w);
      `CHK("manual word", word(9), w)
      `CHK("cal count", 8'h5a, cal)
      `CHK("manual cal", 1'b1, so.manual_cal)
      ce <= 1'b0;
      wr(`REG_CAL_COUNT, 32'ha5);
      ce <= 1'b1;
      i_host.xfer(1'b0, `REG_CAL_COUNT, 32'h0, q);
      `CHK("frozen write", 32'h5a, q)
      dev <= 19'($urandom);
      cmd(`CMD_START_TX, 1'b1, 8'(ch));
      wait_load(400, w);
      ew = word(ch);
      `CHK("tx word", {ew[26:19], ew[18:0] + dev}, w)
      neg <= 1'b1;
      repeat (2) @(negedge pclk);
      `CHK("tx neg", ew[18:0] - dev, so.fraction_word)
      @(posedge pclk);
      neg <= 1'b0;
      $display("test tuning done");
      cmd(`CMD_IDLE, 1'b0, 8'h0);
      wr(`REG_THRESHOLD, 32'h40);
      wr(`REG_TABLE_SIZE, 32'h3);
      wr(`REG_TABLE_BASE, 32'h2);
      wr(`REG_TABLE_BASE + 12'h004, 32'hff);
      wr(`REG_TABLE_BASE + 12'h008, 32'h7);
      wr(`REG_HOP_CONTROL, 32'h29);
      ms.rssi <= 8'($urandom_range(0, 63));
      cmd(`CMD_START_RX, 1'b1, 8'h02);
      wait_load(400, w);
      `CHK("hop start", word(2), w)
      for (int k = 1; k < 5; k++) begin
         wait_load(200, w);
         `CHK("hop word", word(hq[k % 2]), w)
         `CHK("gpio", 1'(k % 2), hop_gpio)
      end
      ms.rssi <= 8'h90;
      repeat (250) @(posedge pclk);
      n = 0;
      repeat (300) begin
         @(negedge pclk);
         if (so.load === 1'b1) n++;
      end
      `CHK("stay loads", 0, n)
      `CHK("above", 1'b1, above_threshold)
      wr(`REG_HOP_CONTROL, 32'h1e);
      ms.rssi <= 8'h10;
      ms.preamble_timeout <= 1'b1;
      ms.sync_timeout <= 1'b1;
      n = 0;
      repeat (300) begin
         @(negedge pclk);
         if (so.load === 1'b1) n++;
      end
      `CHK("raw loads", 0, n)
      wr(`REG_HOP_CONTROL, 32'h0e);
      wait_load(50, w);
      `CHK("timeout hop", word(7), w)
      $display("test hopping done");
      finish_test();
   end
endmodule
`default_nettype wire
